// *** logic/lcm_pkg.sv ***
// constants and types shared by the light curtain muting supervisor
package lcm_pkg;
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned MUTE_LIMIT_S    = 4;
  localparam longint unsigned MUTE_LIMIT_CYC = longint'(MUTE_LIMIT_S) * longint'(CLK_HZ);
  localparam int unsigned TIMER_W         = 30;
  localparam int unsigned OVERLAP_MIN_CYC = 8;
  localparam int unsigned NUM_SENSORS     = 4;
  localparam logic [1:0] LAYOUT_CROSSED   = 2'h0;
  localparam logic [1:0] LAYOUT_PARALLEL  = 2'h1;
  localparam logic [1:0] LAYOUT_EXIT      = 2'h2;
  localparam logic [1:0] LAYOUT_RESERVED  = 2'h3;

  typedef enum logic [2:0] {
    MS_IDLE,
    MS_ARMING,
    MS_MUTED,
    MS_FAULT
  } lcm_state_type;
endpackage

// *** logic/lcm_timer.sv ***
// one-shot cycle counter used as the fail-safe muting timer
`timescale 1ns/100ps
module lcm_timer #(
  parameter int unsigned WIDTH = 30
) (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic             start,
  input  wire logic             stop,
  input  wire logic [WIDTH-1:0] limit,
  output logic                  running,
  output logic                  expired
);
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic             running_q;
  logic             running_d;
  logic             expired_q;
  logic             expired_d;
  wire              at_limit = running_q && (count_q >= limit - WIDTH'(1));

  // start restarts the count even while running, so the grant into muting re-arms it outside the exit layout
  assign running_d = start ? 1'b1 : ((stop || at_limit) ? 1'b0 : running_q);
  assign count_d   = start ? '0 : (running_q ? count_q + WIDTH'(1) : count_q);
  assign expired_d = !start && !stop && at_limit;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      count_q   <= '0;
      running_q <= 1'b0;
      expired_q <= 1'b0;
    end else begin
      count_q   <= count_d;
      running_q <= running_d;
      expired_q <= expired_d;
    end
  end

  assign running = running_q;
  assign expired = expired_q;
endmodule

// *** logic/lcm_muting_ctrl.sv ***
// light curtain muting supervisor: sensor sequence checks, muting timer, output gating
//
// Overview of operation
// - muting starts and ends by itself from the sensor inputs, with no manual command.
// - muting needs at least two independent sensors changing in the right order; one stuck input never mutes.
// - no muting period starts while the safety outputs are off.
// - after power-up the block is unmuted and power cycling alone cannot start muting.
// - muting is granted only while the machine controller asserts its safe-phase enable.
// - every muting period is bounded by a fail-safe timer and protection returns when it expires.
// - sensors that look permanently actuated cannot hold the block muted; such a fault ends unmuted.
// - in the crossed layout the second sensor must be intercepted within 4 s of the first.
// - in the crossed layout muting holds only while both beams stay interrupted.
// - in the parallel layout the four sensors must actuate and release in order with all four briefly together.
// - in the exit layout muting ends once the curtain is clear and either sensor of the pair has released, and at most 4 s after the first sensor clears.
// - with two curtains the one facing the tool stays active and the other is muted, swapping with the tool side.
// - the machine enable stays off while any unmuted beam is interrupted.
// - an optional restart interlock keeps outputs off after a detection until a restart command.
`timescale 1ns/100ps
module lcm_muting_ctrl
  import lcm_pkg::*;
#(
  parameter int unsigned LIMIT_CYC   = 32'(MUTE_LIMIT_CYC),
  parameter int unsigned OVERLAP_CYC = OVERLAP_MIN_CYC
) (
  input  wire logic                   sys_clk,
  input  wire logic                   reset_n,
  input  wire logic [1:0]             layout_select,
  input  wire logic                   first_muting_sensor,
  input  wire logic                   second_muting_sensor,
  input  wire logic                   third_muting_sensor,
  input  wire logic                   fourth_muting_sensor,
  input  wire logic                   curtain_clear,
  input  wire logic                   curtain_b_clear,
  input  wire logic                   machine_safe_phase,
  input  wire logic                   dual_curtain_mode,
  input  wire logic                   tool_on_b_side,
  input  wire logic                   restart_interlock_en,
  input  wire logic                   restart_request,
  output logic                        safety_out_a,
  output logic                        safety_out_b,
  output logic                        muting_active,
  output logic                        muting_fault,
  output logic                        restart_pending
);
  import lcm_pkg::*;

  lcm_state_type    state_q;
  lcm_state_type    state_d;
  logic [3:0]       sens_prev_q;
  logic [3:0]       seen_q;
  logic [3:0]       seen_d;
  logic [7:0]       overlap_q;
  logic [7:0]       overlap_d;
  logic             overlap_ok_q;
  logic             out_a_q;
  logic             out_b_q;
  logic             fault_q;
  logic             lock_q;
  logic             lock_d;
  logic             exit_clearing_q;
  logic             muted_q;
  logic             tmr_start;
  logic             tmr_stop;
  logic             tmr_running;
  logic             tmr_expired;

  wire [3:0] sens      = {fourth_muting_sensor, third_muting_sensor, second_muting_sensor, first_muting_sensor};
  wire [3:0] rise      = sens & ~sens_prev_q;
  wire [3:0] fall      = ~sens & sens_prev_q;
  wire       all_idle  = (sens == 4'h0);
  wire       is_cross  = (layout_select == LAYOUT_CROSSED);
  wire       is_par    = (layout_select == LAYOUT_PARALLEL);
  wire       is_exit   = (layout_select == LAYOUT_EXIT);
  wire       bad_lay   = (layout_select == LAYOUT_RESERVED);
  wire       pair_on   = sens[0] && sens[1];
  // only the first sensor rising alone from idle opens an attempt; two at once is a lone-fault signature
  wire       first_one = (rise == 4'h1) && (sens_prev_q == 4'h0);

  // ordered sequence check: sensor n may only actuate once sensors below it have
  function automatic logic in_order(input logic [3:0] r, input logic [3:0] seen);
    logic ok;
    ok = 1'b1;
    for (int i = 1; i < 4; i++) begin
      if (r[i] && !seen[i-1]) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // parallel release must also follow order: sensor n drops only after sensor n-1
  function automatic logic release_order(input logic [3:0] f, input logic [3:0] s);
    logic ok;
    ok = 1'b1;
    for (int i = 1; i < 4; i++) begin
      if (f[i] && s[i-1]) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  wire par_seq_ok   = in_order(rise, seen_q | rise) && release_order(fall, sens);
  wire cross_grant  = is_cross && pair_on && tmr_running;
  wire par_grant    = is_par && (sens == 4'hF) && overlap_ok_q;
  wire exit_grant   = is_exit && pair_on && tmr_running;
  wire grant_cond   = (cross_grant || par_grant || exit_grant) && machine_safe_phase && out_a_q;

  wire cross_break  = is_cross && !pair_on;
  // lowest sensor dropping first is the normal end of a transit, so only an out-of-order change breaks
  wire par_break    = is_par && !par_seq_ok;
  wire par_done     = is_par && all_idle;
  wire exit_done    = is_exit && curtain_clear && !pair_on;
  wire muted_err    = tmr_expired || par_break || bad_lay;
  wire arm_err      = tmr_expired || bad_lay || (is_par && !par_seq_ok) || (rise != 4'h0 && !is_par && sens[3:2] != 2'h0);

  // next state: transitions are driven by sensors, timers, layout, safe-phase enable and output state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      MS_IDLE:   if (first_one && out_a_q && !bad_lay) state_d = MS_ARMING;
      MS_ARMING: begin
        if (grant_cond) state_d = MS_MUTED;
        else if (arm_err) state_d = MS_FAULT;
        else if (all_idle) state_d = MS_IDLE;
      end
      MS_MUTED: begin
        if (muted_err || !machine_safe_phase) state_d = MS_FAULT;
        else if (cross_break || par_done || exit_done) state_d = MS_IDLE;
      end
      MS_FAULT:  if (all_idle) state_d = MS_IDLE;
      default:   state_d = MS_FAULT;
    endcase
  end

  // timer: starts at the first sensor edge, restarts at the grant outside the exit layout, and at the first clear edge in the exit layout
  wire exit_clear_edge = is_exit && (state_q == MS_MUTED) && !exit_clearing_q && (fall[1:0] != 2'h0);
  assign tmr_start = ((state_q == MS_IDLE) && (state_d == MS_ARMING)) || exit_clear_edge;
  assign tmr_stop  = (state_q == MS_MUTED) && (state_d == MS_IDLE);
  wire   timer_arm = (state_q == MS_ARMING) && (state_d == MS_MUTED) && !is_exit;

  assign seen_d    = (state_q == MS_IDLE) ? rise : (seen_q | rise);
  assign overlap_d = (sens == 4'hF) ? ((overlap_q == 8'hFF) ? overlap_q : overlap_q + 8'h01) : 8'h00;

  // machine enable: beam or unmuted side interrupted drops it; muting only covers the non-tool curtain
  wire mute_a    = (state_q == MS_MUTED) && (!dual_curtain_mode || tool_on_b_side);
  wire mute_b    = (state_q == MS_MUTED) && dual_curtain_mode && !tool_on_b_side;
  wire a_blocked = !curtain_clear && !mute_a;
  wire b_blocked = dual_curtain_mode && !curtain_b_clear && !mute_b;
  wire trip      = a_blocked || b_blocked || (state_d == MS_FAULT);
  assign lock_d  = restart_interlock_en && (trip || (lock_q && !(restart_request && curtain_clear)));
  wire out_en    = !trip && !lock_d;

  lcm_timer #(
    .WIDTH (TIMER_W)
  ) u_timer (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .start   (tmr_start || timer_arm),
    .stop    (tmr_stop),
    .limit   (TIMER_W'(LIMIT_CYC)),
    .running (tmr_running),
    .expired (tmr_expired)
  );

  // reset leaves everything unmuted and outputs off, so a power cycle alone cannot mute
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q     <= MS_IDLE;
      sens_prev_q <= 4'hF;
    end else begin
      state_q     <= state_d;
      sens_prev_q <= sens;
    end
  end

  // parallel-layout sequence memory and overlap qualification
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      seen_q       <= 4'h0;
      overlap_q    <= 8'h00;
      overlap_ok_q <= 1'b0;
    end else begin
      seen_q       <= seen_d;
      overlap_q    <= overlap_d;
      overlap_ok_q <= (overlap_d >= 8'(OVERLAP_CYC));
    end
  end

  // exit layout: remembers that the clear timer has already been started once
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      exit_clearing_q <= 1'b0;
    end else begin
      exit_clearing_q <= (state_d == MS_MUTED) && (exit_clearing_q || exit_clear_edge);
    end
  end

  // every top-level output is registered so no decode glitch reaches the machine
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      out_a_q <= 1'b0;
      out_b_q <= 1'b0;
      fault_q <= 1'b0;
      lock_q  <= 1'b1;
      muted_q <= 1'b0;
    end else begin
      out_a_q <= out_en;
      out_b_q <= out_en;
      fault_q <= (state_d == MS_FAULT);
      lock_q  <= lock_d;
      muted_q <= (state_d == MS_MUTED);
    end
  end

  assign safety_out_a    = out_a_q;
  assign safety_out_b    = out_b_q;
  assign muting_active   = muted_q;
  assign muting_fault    = fault_q;
  assign restart_pending = lock_q;
endmodule

// *** tb/lcm_muting_ctrl_chk.sv ***
// bound assertions for the muting supervisor
`timescale 1ns/100ps
module lcm_chk #(
  parameter int unsigned LIMIT_CYC = 50
) (
  input wire logic       sys_clk,
  input wire logic       reset_n,
  input wire logic [1:0] layout_select,
  input wire logic       first_muting_sensor,
  input wire logic       second_muting_sensor,
  input wire logic       curtain_clear,
  input wire logic       machine_safe_phase,
  input wire logic       dual_curtain_mode,
  input wire logic       safety_out_a,
  input wire logic       muting_active,
  input wire logic       muting_fault
);
  import lcm_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic [31:0] run_q;
  wire         pair = first_muting_sensor && second_muting_sensor;
  // slack of two covers the grant and drop edges around the timer
  always_ff @(posedge sys_clk)
    run_q <= (reset_n && muting_active && layout_select == LAYOUT_CROSSED) ? run_q + 32'h0000_0001 : '0;
  sequence s_grant; !muting_active ##1 muting_active; endsequence
  sequence s_fault2; muting_fault [*2]; endsequence
  property p_rst; disable iff (1'b0) !reset_n |=> !safety_out_a && !muting_active && !muting_fault; endproperty
  a_rst: assert property (p_rst) else $error("not idle after reset");
  property p_safe; s_grant |-> $past(machine_safe_phase); endproperty
  a_safe: assert property (p_safe) else $error("muted outside safe phase");
  property p_pair; s_grant |-> $past(pair); endproperty
  a_pair: assert property (p_pair) else $error("muted without sensor pair");
  property p_on; s_grant |-> $past(safety_out_a); endproperty
  a_on: assert property (p_on) else $error("muted while outputs off");
  property p_flt; s_fault2 |-> !safety_out_a && !muting_active; endproperty
  a_flt: assert property (p_flt) else $error("fault with output on");
  property p_stay; muting_fault && first_muting_sensor |=> muting_fault; endproperty
  a_stay: assert property (p_stay) else $error("fault left with sensor high");
  property p_brk; muting_active && layout_select == LAYOUT_CROSSED && !pair |=> !muting_active; endproperty
  a_brk: assert property (p_brk) else $error("muting held on broken beam");
  property p_lim; run_q <= LIMIT_CYC + 2; endproperty
  a_lim: assert property (p_lim) else $error("muting period too long");
  property p_blk; !dual_curtain_mode && !curtain_clear && !muting_active |=> !safety_out_a; endproperty
  a_blk: assert property (p_blk) else $error("output on with curtain blocked");
endmodule
bind lcm_muting_ctrl lcm_chk #(.LIMIT_CYC(LIMIT_CYC)) u_lcm_chk (.sys_clk, .reset_n, .layout_select,
  .first_muting_sensor, .second_muting_sensor, .curtain_clear, .machine_safe_phase, .dual_curtain_mode,
  .safety_out_a, .muting_active, .muting_fault);

// *** tb/lcm_sensor_model.sv ***
// far-side muting sensors: plays one load transit on request
`timescale 1ns/100ps
module lcm_sensor_model (
  input  wire logic       sys_clk,
  input  wire logic       req,
  input  wire logic       par,
  input  wire logic [7:0] gap,
  input  wire logic [7:0] hold,
  output logic [3:0]      sens,
  output logic            busy
);
  initial sens = 4'h0;
  initial busy = 1'b0;
  // sensors rise in order gap cycles apart and release in the same order
  always @(posedge sys_clk) begin
    if (req && !busy) begin
      busy <= 1'b1;
      for (int i = 0; i < (par ? 4 : 2); i++) begin
        if (i > 0) repeat (gap) @(posedge sys_clk);
        sens[i] <= 1'b1;
      end
      repeat (hold) @(posedge sys_clk);
      for (int i = 0; i < (par ? 4 : 2); i++) begin
        sens[i] <= 1'b0;
        repeat (2) @(posedge sys_clk);
      end
      busy <= 1'b0;
    end
  end
endmodule

// *** tb/lcm_muting_ctrl_tb.sv ***
// self-checking bench for the muting supervisor
`timescale 1ns/100ps
module lcm_muting_ctrl_tb;
  import lcm_pkg::*;
  logic       sys_clk, reset_n, curtain_clear, machine_safe_phase, restart_interlock_en, restart_request;
  logic       curtain_b_clear, dual_curtain_mode, tool_on_b_side, safety_out_b;
  logic       req, par, busy, safety_out_a, muting_active, muting_fault, restart_pending, prev_q, s;
  logic [1:0] layout_select;
  logic [3:0] sens;
  logic [7:0] gap, hold;
  logic       q[$];
  int         err_count, num_checks, seed, g;
  lcm_muting_ctrl #(.LIMIT_CYC(50), .OVERLAP_CYC(8)) u_lcm_muting_ctrl (.sys_clk, .reset_n, .layout_select,
    .first_muting_sensor(sens[0]), .second_muting_sensor(sens[1]), .third_muting_sensor(sens[2]),
    .fourth_muting_sensor(sens[3]), .curtain_clear, .curtain_b_clear, .machine_safe_phase,
    .dual_curtain_mode, .tool_on_b_side, .restart_interlock_en, .restart_request,
    .safety_out_a, .safety_out_b, .muting_active, .muting_fault, .restart_pending);
  lcm_sensor_model u_lcm_sensor_model (.sys_clk, .req, .par, .gap, .hold, .sens, .busy);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic run(input logic [1:0] lay, input logic p, input int gp, input int hd, input logic mutes);
    @(posedge sys_clk);
    layout_select <= lay;
    par <= p;
    gap <= 8'(gp);
    hold <= 8'(hd);
    req <= 1'b1;
    if (mutes) q = {q, 1'b1, 1'b0};
    @(posedge sys_clk);
    req <= 1'b0;
    repeat (2) @(posedge sys_clk);
    while (busy) @(posedge sys_clk);
    repeat (6) @(posedge sys_clk);
    $display("test done layout %0d gap %0d", lay, gp);
  endtask
  // each change of the muting flag consumes the oldest expected edge
  always @(posedge sys_clk) begin
    if (reset_n && muting_active !== prev_q) begin
      if (q.size() == 0) chk(muting_active, prev_q, "unexpected muting change");
      else chk(muting_active, q.pop_front(), "muting edge");
    end
    prev_q <= muting_active;
  end
  initial begin
    repeat (6000) @(posedge sys_clk);
    err_count++;
    $display("MISMATCH at %0t: timeout", $time);
    close_out;
  end
  initial begin
    seed = 32'h1a55_b26e;
    {reset_n, layout_select, restart_request, req, par, gap, hold, prev_q, dual_curtain_mode, tool_on_b_side} = '0;
    {curtain_clear, machine_safe_phase, restart_interlock_en, curtain_b_clear} = 4'hF;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(restart_pending, 1'b1, "interlock not latched");
    chk(safety_out_a, 1'b0, "output on at power-up");
    restart_request <= 1'b1;
    @(posedge sys_clk);
    restart_request <= 1'b0;
    restart_interlock_en <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(safety_out_a, 1'b1, "no restart");
    chk(safety_out_b, 1'b1, "no restart on output b");
    run(LAYOUT_CROSSED, 0, 10, 20, 1);
    machine_safe_phase <= 1'b0;
    run(LAYOUT_CROSSED, 0, 10, 20, 0);
    curtain_clear <= 1'b0;
    run(LAYOUT_CROSSED, 0, 10, 20, 0);
    chk(safety_out_a, 1'b0, "output on while blocked");
    curtain_clear <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      g = 1 + ($unsigned($random(seed)) % 40);
      s = 1'($random(seed));
      machine_safe_phase <= s;
      run(LAYOUT_CROSSED, 0, g, 20, s);
    end
    machine_safe_phase <= 1'b1;
    run(LAYOUT_PARALLEL, 1, 2, 12, 1);
    run(LAYOUT_PARALLEL, 1, 2, 4, 0);
    run(LAYOUT_EXIT, 0, 3, 10, 1);
    run(LAYOUT_CROSSED, 0, 60, 10, 0);
    run(LAYOUT_CROSSED, 0, 0, 10, 0);
    fork
      run(LAYOUT_CROSSED, 0, 5, 80, 1);
      begin
        repeat (70) @(posedge sys_clk);
        chk(muting_fault, 1'b1, "no timeout fault");
        chk(safety_out_a, 1'b0, "output on in fault");
      end
    join
    chk(muting_fault, 1'b0, "fault stuck when idle");
    run(LAYOUT_RESERVED, 0, 3, 10, 0);
    dual_curtain_mode <= 1'b1;
    fork
      run(LAYOUT_CROSSED, 0, 5, 30, 1);
      begin
        repeat (14) @(posedge sys_clk);
        curtain_b_clear <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk(safety_out_a, 1'b1, "muted side b stopped output a");
        chk(safety_out_b, 1'b1, "muted side b stopped output b");
        curtain_b_clear <= 1'b1;
        curtain_clear <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk(safety_out_a, 1'b0, "tool side a blocked, output a on");
        chk(safety_out_b, 1'b0, "tool side a blocked, output b on");
        tool_on_b_side <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk(safety_out_a, 1'b1, "curtain roles not swapped");
        curtain_clear <= 1'b1;
        curtain_b_clear <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk(safety_out_a, 1'b0, "tool side b blocked, output on");
        curtain_b_clear <= 1'b1;
        tool_on_b_side <= 1'b0;
      end
    join
    dual_curtain_mode <= 1'b0;
    chk(q.size() == 0, 1'b1, "expected edges missing");
    close_out;
  end
endmodule
